// file: src/chan_ctrl_if.sv
// Carrier between the register decode and one channel's enable state
`timescale 1ns/10ps
interface chan_ctrl_if;
   logic wr_enable_lane;
   logic wr_run_lane;
   logic [31:0] wdata;
   logic flag_clear_wr;
   logic op_start;
   logic done_event;
   logic dma_ie;
   logic done_ie;
   logic run_enable;
   logic done_flag;
   logic irq_req;

   modport ctrl (
      output wr_enable_lane, wr_run_lane, wdata, flag_clear_wr,
      output op_start, done_event,
      input dma_ie, done_ie, run_enable, done_flag, irq_req
   );
   modport chan (
      input wr_enable_lane, wr_run_lane, wdata, flag_clear_wr,
      input op_start, done_event,
      output dma_ie, done_ie, run_enable, done_flag, irq_req
   );
endinterface : chan_ctrl_if

// file: src/dma_chan_enable.sv
// One channel: interrupt enables, run-enable bit and completion flag
`timescale 1ns/10ps
module dma_chan_enable (
   // Clock and synchronised hard reset
   input wire logic clock,
   input wire logic rst_n,
   // Decode side
   chan_ctrl_if.chan cif
);
   // ****************************************************************
   // Enable state
   // ****************************************************************
   logic dma_ie_reg;
   logic done_ie_reg;
   logic run_enable_reg;
   logic done_flag_reg;

   // Set beats clear when software writes both ones at once
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dma_ie_reg <= dma_irq_pkg::RESET_DMA_IE;
      end else if (cif.wr_enable_lane &&
                   cif.wdata[dma_irq_pkg::DMA_IE_SET_BIT]) begin
         dma_ie_reg <= 1'h1;
      end else if (cif.wr_enable_lane &&
                   cif.wdata[dma_irq_pkg::DMA_IE_CLR_BIT]) begin
         dma_ie_reg <= 1'h0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         done_ie_reg <= dma_irq_pkg::RESET_DONE_IE;
      end else if (cif.wr_enable_lane &&
                   cif.wdata[dma_irq_pkg::DONE_IE_SET_BIT]) begin
         done_ie_reg <= 1'h1;
      end else if (cif.wr_enable_lane &&
                   cif.wdata[dma_irq_pkg::DONE_IE_CLR_BIT]) begin
         done_ie_reg <= 1'h0;
      end
   end

   // Bit 14 is plain storage that software must raise before use
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run_enable_reg <= dma_irq_pkg::RESET_RUN_ENABLE;
      end else if (cif.wr_run_lane) begin
         run_enable_reg <= cif.wdata[dma_irq_pkg::RUN_ENABLE_BIT];
      end
   end

   // A completion arriving with a clear is kept
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         done_flag_reg <= dma_irq_pkg::RESET_DONE_FLAG;
      end else if (cif.done_event) begin
         done_flag_reg <= 1'h1;
      end else if (cif.flag_clear_wr || cif.op_start) begin
         done_flag_reg <= 1'h0;
      end
   end

   assign cif.dma_ie = dma_ie_reg;
   assign cif.done_ie = done_ie_reg;
   assign cif.run_enable = run_enable_reg;
   assign cif.done_flag = done_flag_reg;
   assign cif.irq_req = dma_ie_reg & done_ie_reg & done_flag_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence s_dma_set;
      cif.wr_enable_lane && cif.wdata[dma_irq_pkg::DMA_IE_SET_BIT];
   endsequence
   sequence s_dma_clr_only;
      cif.wr_enable_lane && cif.wdata[dma_irq_pkg::DMA_IE_CLR_BIT] &&
      !cif.wdata[dma_irq_pkg::DMA_IE_SET_BIT];
   endsequence
   sequence s_done_set;
      cif.wr_enable_lane && cif.wdata[dma_irq_pkg::DONE_IE_SET_BIT];
   endsequence
   sequence s_done_clr_only;
      cif.wr_enable_lane && cif.wdata[dma_irq_pkg::DONE_IE_CLR_BIT] &&
      !cif.wdata[dma_irq_pkg::DONE_IE_SET_BIT];
   endsequence

   a_dma_ie_set: assert property (@(posedge clock) disable iff (!rst_n)
      s_dma_set |=> dma_ie_reg [*2] or (dma_ie_reg ##1 !dma_ie_reg))
      else $error("dma enable not set by write");
   a_dma_ie_clear: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_dma_clr_only |=> !dma_ie_reg)
      else $error("dma enable not cleared by write");
   a_done_ie_set: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_done_set |=> done_ie_reg)
      else $error("done enable not set by write");
   a_done_ie_clear: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_done_clr_only |=> !done_ie_reg)
      else $error("done enable not cleared by write");
   a_zero_write_holds: assert property (@(posedge clock)
      disable iff (!rst_n)
      cif.wr_enable_lane && (cif.wdata[31:30] == 2'h0) &&
      (cif.wdata[25:24] == 2'h0) |=> $stable(dma_ie_reg) &&
      $stable(done_ie_reg))
      else $error("zero write changed an enable");
   a_hard_reset_off: assert property (@(posedge clock)
      $rose(rst_n) |-> !dma_ie_reg && !done_ie_reg && !run_enable_reg)
      else $error("enables not cleared by hard reset");
   a_flag_clear_start: assert property (@(posedge clock)
      disable iff (!rst_n)
      (cif.flag_clear_wr || cif.op_start) && !cif.done_event
      |=> !done_flag_reg)
      else $error("completion flag not cleared");
   a_irq_request: assert property (@(posedge clock)
      disable iff (!rst_n)
      cif.done_event && dma_ie_reg && done_ie_reg && !cif.wr_enable_lane
      |=> cif.irq_req)
      else $error("completion did not request interrupt");
endmodule : dma_chan_enable

// file: src/dma_irq_enable_ctrl.sv
// Per-channel interrupt enable bank of a two-channel DMA engine
`timescale 1ns/10ps
// Functional notes
// - Writing one to bit 31 lets the channel drive the shared interrupt.
// - Writing one to bit 30 stops the channel driving the interrupt.
// - Read bit 31 shows interrupt enable, bit 30 its complement.
// - Writing one to bit 25 enables interrupt on channel completion.
// - Writing one to bit 24 disables interrupt on channel completion.
// - Read bit 25 shows completion enable, bit 24 its complement.
// - Writing zero to any set or clear bit changes nothing.
// - Hard reset clears both enables; soft reset leaves them alone.
// - One interrupt output shared by both channels per their enables.
// - Bit 14 cleared by hard reset, kept by soft; software sets it.
// - Software writes zero to reserved bits; reads there are undefined.
// - Completion flag clears on done-clear write or new operation start.
module dma_irq_enable_ctrl #(
   parameter int unsigned CHANNELS = dma_irq_pkg::MAX_CHANNELS
) (
   // Clock and hard reset
   input wire logic clock,
   input wire logic resetn,
   // Soft reset from the engine; enables ignore it by design
   input wire logic soft_reset,
   // Register port at the documented offsets
   input wire logic reg_select,
   input wire logic reg_write,
   input wire logic [dma_irq_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [3:0] reg_byte_en,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_ack,
   // Transfer engine
   input wire logic [CHANNELS-1:0] op_start,
   input wire logic [CHANNELS-1:0] done_event,
   output logic [CHANNELS-1:0] done_flag,
   output logic [CHANNELS-1:0] run_enable,
   // Shared DMA interrupt
   output logic dma_irq
);
   // ****************************************************************
   // Parameter check
   // ****************************************************************
   if (CHANNELS < 1 || CHANNELS > dma_irq_pkg::MAX_CHANNELS) begin : g_bad
      $error("CHANNELS must be 1 or 2");
   end

   // ****************************************************************
   // Decode helpers
   // ****************************************************************
   function automatic logic [11:0] control_ofs(input int unsigned ch);
      control_ofs = (ch == 0) ? dma_irq_pkg::CH1_CONTROL_OFS
                              : dma_irq_pkg::CH2_CONTROL_OFS;
   endfunction : control_ofs

   function automatic logic [11:0] operation_ofs(input int unsigned ch);
      operation_ofs = (ch == 0) ? dma_irq_pkg::CH1_OPERATION_OFS
                                : dma_irq_pkg::CH2_OPERATION_OFS;
   endfunction : operation_ofs

   // Reserved positions read as zero; software must not rely on it
   function automatic logic [31:0] control_word(input logic dma_ie,
                                                input logic done_ie,
                                                input logic run);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[dma_irq_pkg::DMA_IE_SET_BIT] = dma_ie;
      w[dma_irq_pkg::DMA_IE_CLR_BIT] = ~dma_ie;
      w[dma_irq_pkg::DONE_IE_SET_BIT] = done_ie;
      w[dma_irq_pkg::DONE_IE_CLR_BIT] = ~done_ie;
      w[dma_irq_pkg::RUN_ENABLE_BIT] = run;
      control_word = w;
   endfunction : control_word

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_meta_reg <= 1'h0;
         rst_n <= 1'h0;
      end else begin
         rst_meta_reg <= 1'h1;
         rst_n <= rst_meta_reg;
      end
   end

   // ****************************************************************
   // Channels
   // ****************************************************************
   chan_ctrl_if cif [CHANNELS] ();
   logic [CHANNELS-1:0] irq_req;
   logic [CHANNELS-1:0] ch_dma_ie;
   logic [CHANNELS-1:0] ch_done_ie;
   logic [CHANNELS-1:0] ch_run;
   logic [CHANNELS-1:0] ch_flag;
   logic [CHANNELS-1:0] hit_control;
   logic write_cycle;

   assign write_cycle = reg_select && reg_write;

   for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
      // Each lane steers only the fields it carries
      assign hit_control[c] = (reg_addr == control_ofs(c));
      assign cif[c].wr_enable_lane = write_cycle && hit_control[c] &&
         reg_byte_en[dma_irq_pkg::ENABLE_LANE];
      assign cif[c].wr_run_lane = write_cycle && hit_control[c] &&
         reg_byte_en[dma_irq_pkg::RUN_LANE];
      assign cif[c].wdata = reg_wdata;
      assign cif[c].flag_clear_wr = write_cycle &&
         (reg_addr == operation_ofs(c)) &&
         reg_byte_en[dma_irq_pkg::FLAG_LANE] &&
         reg_wdata[dma_irq_pkg::FLAG_CLEAR_BIT];
      assign cif[c].op_start = op_start[c];
      assign cif[c].done_event = done_event[c];
      assign irq_req[c] = cif[c].irq_req;
      assign ch_dma_ie[c] = cif[c].dma_ie;
      assign ch_done_ie[c] = cif[c].done_ie;
      assign ch_run[c] = cif[c].run_enable;
      assign ch_flag[c] = cif[c].done_flag;

      dma_chan_enable u_chan (
         .clock (clock),
         .rst_n (rst_n),
         .cif (cif[c])
      );
   end

   assign done_flag = ch_flag;
   assign run_enable = ch_run;

   // ****************************************************************
   // Shared interrupt
   // ****************************************************************
   // Registered so the pin never glitches while flags and enables move
   logic irq_reg;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_reg <= 1'h0;
      end else begin
         irq_reg <= |irq_req;
      end
   end

   assign dma_irq = irq_reg;

   // ****************************************************************
   // Read path
   // ****************************************************************
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic ack_reg;

   always_comb begin
      rdata_next = dma_irq_pkg::RESET_READ_DATA;
      for (int unsigned c = 0; c < CHANNELS; c++) begin
         if (hit_control[c]) begin
            rdata_next = control_word(ch_dma_ie[c], ch_done_ie[c],
                                      ch_run[c]);
         end
      end
   end

   // Every access is answered in the next cycle, mapped or not
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'h0;
      end else begin
         ack_reg <= reg_select;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= dma_irq_pkg::RESET_READ_DATA;
      end else if (reg_select && !reg_write) begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_ack = ack_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence s_read_control;
      reg_select && !reg_write && (|hit_control);
   endsequence

   a_read_complement: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_read_control ##1 reg_ack |->
      (reg_rdata[dma_irq_pkg::DMA_IE_SET_BIT] !=
       reg_rdata[dma_irq_pkg::DMA_IE_CLR_BIT]))
      else $error("dma enable read bits not complementary");
   a_read_done_pair: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_read_control ##1 reg_ack |->
      (reg_rdata[dma_irq_pkg::DONE_IE_SET_BIT] ==
       $past(|(ch_done_ie & hit_control))) &&
      (reg_rdata[dma_irq_pkg::DONE_IE_CLR_BIT] !=
       reg_rdata[dma_irq_pkg::DONE_IE_SET_BIT]))
      else $error("done enable read back wrong");
   a_soft_keeps: assert property (@(posedge clock) disable iff (!rst_n)
      soft_reset && !write_cycle |=> $stable(ch_dma_ie) &&
      $stable(ch_done_ie) && $stable(ch_run))
      else $error("soft reset disturbed enables");
   a_irq_shared: assert property (@(posedge clock) disable iff (!rst_n)
      (|irq_req) |=> dma_irq)
      else $error("shared interrupt missed a channel");
   a_irq_cause: assert property (@(posedge clock) disable iff (!rst_n)
      dma_irq |-> $past(|(ch_dma_ie & ch_done_ie & ch_flag)))
      else $error("interrupt without enabled completion");
   a_run_bit_kept: assert property (@(posedge clock)
      disable iff (!rst_n)
      !(|hit_control && write_cycle) |=> $stable(ch_run))
      else $error("run enable bit changed without write");

   // ****************************************************************
   // Checks on read-back, write steering and the engine side
   // ****************************************************************
   // Engine checks watch channel 0, which every legal CHANNELS keeps
   sequence s_ctl_write;
      write_cycle && (|hit_control);
   endsequence
   sequence s_dma_set_write;
      s_ctl_write ##0 reg_byte_en[dma_irq_pkg::ENABLE_LANE] &&
      reg_wdata[dma_irq_pkg::DMA_IE_SET_BIT];
   endsequence
   sequence s_done_set_write;
      s_ctl_write ##0 reg_byte_en[dma_irq_pkg::ENABLE_LANE] &&
      reg_wdata[dma_irq_pkg::DONE_IE_SET_BIT];
   endsequence
   sequence s_done_armed;
      done_event[0] && ch_dma_ie[0] && ch_done_ie[0] && !write_cycle;
   endsequence

   a_read_dma_bit: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_read_control ##1 reg_ack |->
      (reg_rdata[dma_irq_pkg::DMA_IE_SET_BIT] ==
       $past(|(ch_dma_ie & hit_control))))
      else $error("dma enable read back wrong");
   a_read_run_bit: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_read_control ##1 reg_ack |->
      (reg_rdata[dma_irq_pkg::RUN_ENABLE_BIT] ==
       $past(|(ch_run & hit_control))))
      else $error("bit 14 read back wrong");
   a_read_reserved: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_read_control ##1 reg_ack |->
      ((reg_rdata & 32'h3CFF_BFFF) == 32'h0000_0000))
      else $error("reserved bits not read as zero");
   a_read_unmapped: assert property (@(posedge clock)
      disable iff (!rst_n)
      reg_select && !reg_write && !(|hit_control) |=>
      (reg_rdata == 32'h0000_0000))
      else $error("unmapped read returned data");
   a_set_dma_top: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_dma_set_write |=> |(ch_dma_ie & $past(hit_control)))
      else $error("dma enable set missed its channel");
   a_set_done_top: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_done_set_write |=> |(ch_done_ie & $past(hit_control)))
      else $error("done enable set missed its channel");
   a_clear_dma_top: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_ctl_write ##0 reg_byte_en[dma_irq_pkg::ENABLE_LANE] &&
      reg_wdata[dma_irq_pkg::DMA_IE_CLR_BIT] &&
      !reg_wdata[dma_irq_pkg::DMA_IE_SET_BIT] |=>
      !(|(ch_dma_ie & $past(hit_control))))
      else $error("dma enable clear missed its channel");
   a_clear_done_top: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_ctl_write ##0 reg_byte_en[dma_irq_pkg::ENABLE_LANE] &&
      reg_wdata[dma_irq_pkg::DONE_IE_CLR_BIT] &&
      !reg_wdata[dma_irq_pkg::DONE_IE_SET_BIT] |=>
      !(|(ch_done_ie & $past(hit_control))))
      else $error("done enable clear missed its channel");
   a_lane_gate: assert property (@(posedge clock)
      disable iff (!rst_n)
      write_cycle && !reg_byte_en[dma_irq_pkg::ENABLE_LANE] |=>
      $stable(ch_dma_ie) && $stable(ch_done_ie))
      else $error("enable moved without its lane");
   a_run_write: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_ctl_write ##0 reg_byte_en[dma_irq_pkg::RUN_LANE] |=>
      ((|(ch_run & $past(hit_control))) ==
       $past(reg_wdata[dma_irq_pkg::RUN_ENABLE_BIT])))
      else $error("bit 14 not stored as written");
   a_reset_quiet: assert property (@(posedge clock)
      $rose(rst_n) |-> !dma_irq && !(|ch_dma_ie) && !(|ch_done_ie) &&
      !(|ch_run) && !(|ch_flag) && !reg_ack)
      else $error("state not cleared by hard reset");
   a_flag_by_write: assert property (@(posedge clock)
      disable iff (!rst_n)
      write_cycle && (reg_addr == operation_ofs(0)) && !done_event[0] &&
      reg_byte_en[dma_irq_pkg::FLAG_LANE] &&
      reg_wdata[dma_irq_pkg::FLAG_CLEAR_BIT] |=> !ch_flag[0])
      else $error("flag clear write ignored");
   a_flag_by_start: assert property (@(posedge clock)
      disable iff (!rst_n)
      op_start[0] && !done_event[0] |=> !ch_flag[0])
      else $error("operation start left flag set");
   a_flag_by_done: assert property (@(posedge clock)
      disable iff (!rst_n)
      done_event[0] |=> ch_flag[0])
      else $error("completion did not set flag");
   a_irq_delay: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_done_armed |-> ##2 dma_irq)
      else $error("shared interrupt late for completion");
   a_irq_release: assert property (@(posedge clock)
      disable iff (!rst_n)
      !(|irq_req) |=> !dma_irq)
      else $error("interrupt held without request");
endmodule : dma_irq_enable_ctrl

// file: src/dma_irq_pkg.sv
// Constants shared by the DMA channel interrupt enable bank
package dma_irq_pkg;
   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] CH1_OPERATION_OFS = 12'hD00;
   localparam logic [11:0] CH1_CONTROL_OFS = 12'hD04;
   localparam logic [11:0] CH2_OPERATION_OFS = 12'hE00;
   localparam logic [11:0] CH2_CONTROL_OFS = 12'hE04;
   localparam int unsigned MAX_CHANNELS = 2;

   // ****************************************************************
   // Field positions and byte lanes
   // ****************************************************************
   localparam int unsigned DMA_IE_SET_BIT = 31;
   localparam int unsigned DMA_IE_CLR_BIT = 30;
   localparam int unsigned DONE_IE_SET_BIT = 25;
   localparam int unsigned DONE_IE_CLR_BIT = 24;
   localparam int unsigned RUN_ENABLE_BIT = 14;
   localparam int unsigned FLAG_CLEAR_BIT = 7;
   localparam int unsigned ENABLE_LANE = 3;
   localparam int unsigned RUN_LANE = 1;
   localparam int unsigned FLAG_LANE = 0;

   // ****************************************************************
   // Values after hard reset
   // ****************************************************************
   localparam logic RESET_DMA_IE = 1'h0;
   localparam logic RESET_DONE_IE = 1'h0;
   localparam logic RESET_RUN_ENABLE = 1'h0;
   localparam logic RESET_DONE_FLAG = 1'h0;
   localparam logic [31:0] RESET_READ_DATA = 32'h0000_0000;
endpackage : dma_irq_pkg

// file: verification/dma_irq_enable_ctrl_test.sv
// Self-checking bench for the DMA channel interrupt enable bank
`timescale 1ns/10ps
module dma_irq_enable_ctrl_test;
   // ****************************************************************
   // Signals and bench state
   // ****************************************************************
   typedef struct {logic [31:0] data; logic [31:0] mask;} rd_note_t;
   // Reserved bits read back undefined, so only defined fields compare
   localparam logic [31:0] CTL_MASK = 32'hC300_4000;
   localparam int TIMEOUT = 5000;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic soft_reset = 1'b0;
   logic reg_select = 1'b0;
   logic reg_write = 1'b0;
   logic [dma_irq_pkg::ADDR_W-1:0] reg_addr = 12'h000;
   logic [3:0] reg_byte_en = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic [31:0] reg_rdata;
   logic reg_ack;
   logic [1:0] op_start = 2'h0;
   logic [1:0] done_event = 2'h0;
   logic [1:0] done_flag;
   logic [1:0] run_enable;
   logic dma_irq;
   logic sel_d = 1'b0;
   logic rd_d = 1'b0;
   logic exp_dma [2];
   logic exp_done [2];
   logic exp_run [2];
   logic [31:0] seed = 32'hC14C;
   logic [31:0] d;
   logic [3:0] be;
   logic [1:0] en;
   logic [1:0] ev;
   logic [11:0] op_addr;
   rd_note_t notes [$];
   rd_note_t note;
   int n_fail = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #5 clock = ~clock;

   dma_irq_enable_ctrl #(.CHANNELS(2)) uut (
      .clock(clock), .resetn(resetn), .soft_reset(soft_reset),
      .reg_select(reg_select), .reg_write(reg_write),
      .reg_addr(reg_addr), .reg_byte_en(reg_byte_en),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .op_start(op_start), .done_event(done_event),
      .done_flag(done_flag), .run_enable(run_enable), .dma_irq(dma_irq)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [11:0] ctl_addr(input int c);
      return c ? dma_irq_pkg::CH2_CONTROL_OFS : dma_irq_pkg::CH1_CONTROL_OFS;
   endfunction : ctl_addr

   function automatic logic [31:0] exp_ctl(input int c);
      return {exp_dma[c], ~exp_dma[c], 4'h0, exp_done[c], ~exp_done[c],
              9'h000, exp_run[c], 14'h0000};
   endfunction : exp_ctl

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic access(input logic wr, input logic [11:0] a,
                         input logic [3:0] b, input logic [31:0] v);
      @(posedge clock);
      reg_select <= 1'b1;
      reg_write <= wr;
      reg_addr <= a;
      reg_byte_en <= b;
      reg_wdata <= v;
   endtask : access

   task automatic rd(input logic [11:0] a, input logic [31:0] v,
                     input logic [31:0] m);
      notes.push_back('{v, m});
      access(1'b0, a, 4'hF, 32'h0000_0000);
   endtask : rd

   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clock);
         reg_select <= 1'b0;
         op_start <= 2'h0;
         done_event <= 2'h0;
      end
   endtask : idle

   // Mirror of the enable state; set wins when both bits are written
   task automatic model(input int c, input logic [3:0] b,
                        input logic [31:0] v);
      if (b[3] && v[31]) exp_dma[c] = 1'b1;
      else if (b[3] && v[30]) exp_dma[c] = 1'b0;
      if (b[3] && v[25]) exp_done[c] = 1'b1;
      else if (b[3] && v[24]) exp_done[c] = 1'b0;
      if (b[1]) exp_run[c] = v[14];
   endtask : model

   task automatic clear_model;
      for (int c = 0; c < 2; c++) begin
         exp_dma[c] = 1'b0;
         exp_done[c] = 1'b0;
         exp_run[c] = 1'b0;
      end
   endtask : clear_model

   task automatic final_report;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   // ****************************************************************
   // Output watcher: every access is answered, reads against notes
   // ****************************************************************
   always @(posedge clock) begin
      sel_d <= reg_select;
      rd_d <= reg_select & ~reg_write;
      if (sel_d) begin
         chk("reg_ack", 32'h1, {31'h0, reg_ack});
         if (rd_d && notes.size() > 0) begin
            note = notes.pop_front();
            chk("reg_rdata", note.data & note.mask,
                reg_rdata & note.mask);
         end
      end else if (resetn) begin
         // No acknowledge unless the cycle before held an access
         chk("reg_ack", 32'h0, {31'h0, reg_ack});
      end
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == TIMEOUT) begin
         n_fail++;
         final_report();
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      idle(3);
      clear_model();
      for (int c = 0; c < 2; c++) begin
         rd(ctl_addr(c), exp_ctl(c), CTL_MASK);
      end
      rd(12'h100, 32'h0000_0000, 32'hFFFF_FFFF);
      access(1'b1, 12'h100, 4'hF, 32'hFFFF_FFFF);
      // Random set/clear mixes, lanes on or off, read back at once
      repeat (60) begin
         seed = lfsr(seed);
         be = {seed[1], 1'b0, seed[2], 1'b0};
         d = {seed[3], seed[4], 4'h0, seed[5], seed[6], 9'h000, seed[7],
              14'h0000};
         access(1'b1, ctl_addr(int'(seed[0])), be, d);
         model(int'(seed[0]), be, d);
         rd(ctl_addr(int'(seed[0])), exp_ctl(int'(seed[0])),
            CTL_MASK);
      end
      // All-zero write on the enable lane must leave both enables
      access(1'b1, ctl_addr(0), 4'h8, 32'h0000_0000);
      rd(ctl_addr(0), exp_ctl(0), CTL_MASK);
      idle(2);
      chk("run_enable", {30'h0, exp_run[1], exp_run[0]},
          {30'h0, run_enable});
      // Soft reset must leave every enable and bit 14 alone
      @(posedge clock);
      soft_reset <= 1'b1;
      idle(4);
      @(posedge clock);
      soft_reset <= 1'b0;
      for (int c = 0; c < 2; c++) begin
         rd(ctl_addr(c), exp_ctl(c), CTL_MASK);
      end
      // Shared interrupt over every enable and completion pattern
      for (int i = 0; i < 16; i++) begin
         en = i[1:0];
         ev = i[3:2];
         for (int c = 0; c < 2; c++) begin
            seed = lfsr(seed);
            d = en[c] ? 32'h8200_4000
                      : (seed[0] ? 32'h8100_4000 : 32'h4200_4000);
            access(1'b1, ctl_addr(c), 4'hA, d);
            model(c, 4'hA, d);
         end
         @(posedge clock);
         reg_select <= 1'b0;
         done_event <= ev;
         idle(3);
         #1;
         chk("done_flag", {30'h0, ev}, {30'h0, done_flag});
         chk("dma_irq", {31'h0, |(en & ev)}, {31'h0, dma_irq});
         // Alternate which channel is cleared by write and which by start
         op_addr = i[0] ? dma_irq_pkg::CH2_OPERATION_OFS
                        : dma_irq_pkg::CH1_OPERATION_OFS;
         access(1'b1, op_addr, 4'h1, 32'h0000_0080);
         op_start <= i[0] ? 2'h1 : 2'h2;
         idle(3);
         #1;
         chk("done_flag", 32'h0, {30'h0, done_flag});
         chk("dma_irq", 32'h0, {31'h0, dma_irq});
      end
      // Hard reset in mid-run drops enables and bit 14
      @(posedge clock);
      resetn <= 1'b0;
      idle(2);
      @(posedge clock);
      resetn <= 1'b1;
      idle(3);
      clear_model();
      chk("run_enable", 32'h0, {30'h0, run_enable});
      for (int c = 0; c < 2; c++) begin
         rd(ctl_addr(c), exp_ctl(c), CTL_MASK);
      end
      idle(4);
      final_report();
   end
endmodule : dma_irq_enable_ctrl_test
